//--- pkg/frame_timing_regs.vh
// register map, field positions, reset values and sizes of the frame
// timing and pixel clock block; definitions only
`ifndef FRAME_TIMING_REGS_VH
`define FRAME_TIMING_REGS_VH

// printed register indices; byte address is four times the index
`define IDX_VERT_BLANK_A 8'h08
`define IDX_INTEG_ROWS 8'h09
`define IDX_PIX_CLK_CFG 8'h0a
`define IDX_FRAME_PAD 8'h0b
`define IDX_FRAME_CTRL 8'h0c
`define IDX_FRAME_STAT 8'h0d

// reset values
`define RST_VERT_BLANK_A 15'h0011
`define RST_INTEG_ROWS 16'h0219
`define RST_PIX_SPEED 4'h1
`define RST_PIX_DELAY 4'h1
`define RST_PIX_INVERT 1'b0
`define RST_FRAME_PAD 14'h0000

// pixel_clock_config fields
`define PCC_SPEED_LSB 0
`define PCC_DELAY_LSB 4
`define PCC_INVERT_BIT 8

// frame_ctrl fields
`define CTL_HOLD_BIT 0
`define CTL_ALL_FRAMES_BIT 1
`define CTL_LOW_POWER_BIT 2

// frame geometry defaults
`define DEF_WIN_ROWS 11'h400
`define DEF_WIN_COLS 11'h500
`define DEF_HBLANK 11'h0be

`endif

//--- verilog/span_counter.v
// up counter that restarts at zero after reaching a programmable limit
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module span_counter #(
    parameter W = 16
) (
    input wire core_clk, // clock, two per master clock
    input wire rst, // synchronous reset, active high
    input wire clr, // force count to zero
    input wire step, // advance by one
    input wire [W-1:0] limit, // last count before wrap
    output reg [W-1:0] count_ff, // present count
    output wire at_last // count equals limit
);

assign at_last = (count_ff == limit);

always @(posedge core_clk) begin
    if (rst || clr) begin
        count_ff <= {W{1'b0}};
    end else if (step) begin
        count_ff <= at_last ? {W{1'b0}} : count_ff + {{(W-1){1'b0}}, 1'b1};
    end
end

endmodule
`default_nettype wire

//--- verilog/pixel_clock_gen.v
// pixel clock generator: period, inversion and half-master-clock delay
// assumes core_clk toggles at twice the master clock, so one core cycle
// is half a master clock period
`timescale 1ns/1ps
`default_nettype none
module pixel_clock_gen (
    input wire core_clk, // clock, two per master clock
    input wire rst, // synchronous reset, active high
    input wire [3:0] speed, // period in master clocks, 0 taken as 1
    input wire low_power, // low-power readout doubles the period
    input wire invert, // data changes on the falling edge
    input wire [3:0] delay, // clock delay in half master clocks
    output wire tick, // one cycle at the data change point
    output reg clk_out_ff // generated pixel clock
);

reg [5:0] phase_ff;
reg [14:0] taps_ff;
wire [5:0] nxt_phase;
wire [3:0] speed_eff;
wire [5:0] half;
wire base;

assign speed_eff = (speed == 4'h0) ? 4'h1 : speed;
// low-power doubles the pixel period, converter period unchanged
assign half = low_power ? {1'b0, speed_eff, 1'b0} : {2'b00, speed_eff};
assign tick = (phase_ff == 6'h00);
assign nxt_phase = (phase_ff >= {half[4:0], 1'b0} - 6'h01) ? 6'h00
                   : phase_ff + 6'h01;
// looks one phase ahead: the top registers the clock once more, and its
// edge must land with the syncs that are registered at the tick
// high for half the period after the data change, swapped by invert
assign base = (nxt_phase < half) ^ invert;

always @(posedge core_clk) begin
    if (rst) begin
        phase_ff <= 6'h00;
        taps_ff <= 15'h0000;
        clk_out_ff <= 1'b0;
    end else begin
        phase_ff <= nxt_phase;
        taps_ff <= {taps_ff[13:0], base};
        // each tap is one half master clock later
        clk_out_ff <= (delay == 4'h0) ? base : taps_ff[delay - 4'h1];
    end
end

endmodule
`default_nettype wire

//--- verilog/frame_timing_ctrl.v
// frame timing and pixel clock control with an apb register slave
// assumes one clock and a master that follows apb setup/access phases
`timescale 1ns/1ps
`default_nettype none
`include "frame_timing_regs.vh"
module frame_timing_ctrl #(
    parameter DATA_W = 8,
    parameter [10:0] WIN_ROWS = `DEF_WIN_ROWS,
    parameter [10:0] WIN_COLS = `DEF_WIN_COLS,
    parameter [10:0] HBLANK = `DEF_HBLANK
) (
    input wire core_clk, // clock, two per master clock
    input wire rst, // synchronous reset, active high
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error, unmapped address
    output reg line_valid_out, // row of pixels valid
    output reg frame_valid_out, // frame valid
    output reg [DATA_W-1:0] pixel_data_out, // pixel data
    output reg pixel_clock_out, // pixel clock to the receiver
    output reg [15:0] shutter_row_out // row being reset for integration
);

localparam ST_ACTIVE = 3'b001;
localparam ST_VBLANK = 3'b010;
localparam ST_PAD = 3'b100;
localparam [11:0] ROW_LEN_M1 = {1'b0, WIN_COLS} + {1'b0, HBLANK} - 12'h001;

////////////////////////////////////////////////////////////////////////////
// software registers

reg [14:0] vblank_ff;
reg [15:0] integ_ff;
reg [3:0] speed_ff;
reg [3:0] delay_ff;
reg invert_ff;
reg [13:0] pad_ff;
reg hold_ff;
reg all_frames_ff;
reg low_power_ff;
reg bad_ff;
reg [15:0] frame_cnt_ff;
reg [2:0] state_ff;

wire [9:0] word_idx;
wire idx_ok;
wire setup;
wire wr_en;
reg [31:0] nxt_rdata;
reg nxt_err;

assign word_idx = paddr[11:2];
assign setup = psel && !penable;
assign wr_en = psel && penable && pready && pwrite && !pslverr;

always @* begin
    nxt_err = 1'b0;
    nxt_rdata = 32'h00000000;
    case (word_idx)
        {2'b00, `IDX_VERT_BLANK_A}: nxt_rdata = {17'h00000, vblank_ff};
        {2'b00, `IDX_INTEG_ROWS}: nxt_rdata = {16'h0000, integ_ff};
        {2'b00, `IDX_PIX_CLK_CFG}: nxt_rdata = {23'h000000, invert_ff,
                                            delay_ff, speed_ff};
        {2'b00, `IDX_FRAME_PAD}: nxt_rdata = {18'h00000, pad_ff};
        {2'b00, `IDX_FRAME_CTRL}: nxt_rdata = {29'h00000000, low_power_ff,
                                           all_frames_ff, hold_ff};
        {2'b00, `IDX_FRAME_STAT}: nxt_rdata = {frame_cnt_ff, 8'h00,
                                           5'h00, bad_ff, state_ff[0],
                                           frame_valid_out};
        default: nxt_err = 1'b1;
    endcase
end

// answer in the access phase right after setup: one cycle, no waits
always @(posedge core_clk) begin
    if (rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        pready <= setup;
        pslverr <= setup && nxt_err;
        prdata <= (setup && !pwrite) ? nxt_rdata : 32'h00000000;
    end
end

always @(posedge core_clk) begin
    if (rst) begin
        vblank_ff <= `RST_VERT_BLANK_A;
        integ_ff <= `RST_INTEG_ROWS;
        speed_ff <= `RST_PIX_SPEED;
        delay_ff <= `RST_PIX_DELAY;
        invert_ff <= `RST_PIX_INVERT;
        pad_ff <= `RST_FRAME_PAD;
        hold_ff <= 1'b0;
        all_frames_ff <= 1'b0;
        low_power_ff <= 1'b0;
    end else if (wr_en) begin
        case (word_idx)
            {2'b00, `IDX_VERT_BLANK_A}: vblank_ff <= pwdata[14:0];
            {2'b00, `IDX_INTEG_ROWS}: integ_ff <= pwdata[15:0];
            {2'b00, `IDX_PIX_CLK_CFG}: begin
                speed_ff <= pwdata[`PCC_SPEED_LSB+3:`PCC_SPEED_LSB];
                delay_ff <= pwdata[`PCC_DELAY_LSB+3:`PCC_DELAY_LSB];
                invert_ff <= pwdata[`PCC_INVERT_BIT];
            end
            {2'b00, `IDX_FRAME_PAD}: pad_ff <= pwdata[13:0];
            {2'b00, `IDX_FRAME_CTRL}: begin
                hold_ff <= pwdata[`CTL_HOLD_BIT];
                all_frames_ff <= pwdata[`CTL_ALL_FRAMES_BIT];
                low_power_ff <= pwdata[`CTL_LOW_POWER_BIT];
            end
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// frame-synchronised shadows and bad-frame marking

reg [14:0] vblank_sh_ff;
reg [15:0] integ_sh_ff;
reg [3:0] speed_sh_ff;
reg [13:0] pad_sh_ff;
reg low_power_sh_ff;
wire frame_end;
wire changed;

// only the pixel clock period and extra blanking mark a frame bad here
assign changed = (speed_ff != speed_sh_ff) || (pad_ff != pad_sh_ff)
                 || (low_power_ff != low_power_sh_ff);

always @(posedge core_clk) begin
    if (rst) begin
        vblank_sh_ff <= `RST_VERT_BLANK_A;
        integ_sh_ff <= `RST_INTEG_ROWS;
        speed_sh_ff <= `RST_PIX_SPEED;
        pad_sh_ff <= `RST_FRAME_PAD;
        low_power_sh_ff <= 1'b0;
        bad_ff <= 1'b0;
        frame_cnt_ff <= 16'h0000;
    end else if (frame_end) begin
        frame_cnt_ff <= frame_cnt_ff + 16'h0001;
        if (!hold_ff) begin
            vblank_sh_ff <= vblank_ff;
            integ_sh_ff <= integ_ff;
            speed_sh_ff <= speed_ff;
            pad_sh_ff <= pad_ff;
            low_power_sh_ff <= low_power_ff;
            bad_ff <= changed;
        end else begin
            bad_ff <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// pixel clock and frame sequencer

wire tick;
wire pclk_raw;
wire [11:0] col;
wire [15:0] row;
wire [13:0] pad_cnt;
wire col_last;
wire row_last;
wire pad_last;
reg [15:0] row_limit;
reg [2:0] nxt_state;
wire row_end;

pixel_clock_gen u_pclk (
    .core_clk(core_clk),
    .rst(rst),
    .speed(speed_sh_ff),
    .low_power(low_power_sh_ff),
    .invert(invert_ff),
    .delay(delay_ff),
    .tick(tick),
    .clk_out_ff(pclk_raw)
);

span_counter #(.W(12)) u_col (
    .core_clk(core_clk),
    .rst(rst),
    .clr(1'b0),
    .step(tick && !state_ff[2]),
    .limit(ROW_LEN_M1),
    .count_ff(col),
    .at_last(col_last)
);

assign row_end = tick && !state_ff[2] && col_last;

always @* begin
    row_limit = {5'h00, WIN_ROWS} - 16'h0001;
    if (state_ff[1]) begin
        row_limit = {1'b0, vblank_sh_ff} - 16'h0001;
    end
end

span_counter #(.W(16)) u_row (
    .core_clk(core_clk),
    .rst(rst),
    .clr(state_ff != nxt_state),
    .step(row_end),
    .limit(row_limit),
    .count_ff(row),
    .at_last(row_last)
);

span_counter #(.W(14)) u_pad (
    .core_clk(core_clk),
    .rst(rst),
    .clr(!state_ff[2]),
    .step(tick && state_ff[2]),
    .limit(pad_sh_ff - 14'h0001),
    .count_ff(pad_cnt),
    .at_last(pad_last)
);

// extra blanking also stalls the shutter pointer, so rows reset near the
// frame end integrate longer; this follows the sensor and is kept
always @* begin
    nxt_state = state_ff;
    case (state_ff)
        ST_ACTIVE: begin
            if (row_end && row_last) begin
                if (vblank_sh_ff != 15'h0000) begin
                    nxt_state = ST_VBLANK;
                end else if (pad_sh_ff != 14'h0000) begin
                    nxt_state = ST_PAD;
                end
            end
        end
        ST_VBLANK: begin
            if (row_end && row_last) begin
                nxt_state = (pad_sh_ff != 14'h0000) ? ST_PAD : ST_ACTIVE;
            end
        end
        ST_PAD: begin
            if (tick && pad_last) begin
                nxt_state = ST_ACTIVE;
            end
        end
        default: nxt_state = ST_ACTIVE;
    endcase
end

assign frame_end = (nxt_state == ST_ACTIVE) && (state_ff != ST_ACTIVE
                   || (row_end && row_last));

always @(posedge core_clk) begin
    if (rst) begin
        state_ff <= ST_ACTIVE;
    end else begin
        state_ff <= nxt_state;
    end
end

////////////////////////////////////////////////////////////////////////////
// outputs, syncs and data moving together one cycle after the tick; the pixel clock edge comes delay_ff cycles later

wire show;
reg [15:0] total_rows;
reg [16:0] shutter_sum;
reg [15:0] read_row;

// a bad frame keeps both syncs low unless all frames are wanted
assign show = !bad_ff || all_frames_ff;

always @* begin
    total_rows = {5'h00, WIN_ROWS} + {1'b0, vblank_sh_ff};
    read_row = state_ff[1] ? row + {5'h00, WIN_ROWS} : row;
    shutter_sum = {1'b0, read_row} + {1'b0, integ_sh_ff};
    // a divider, but the pointer stays a real row for any integration
    shutter_sum = shutter_sum % {1'b0, total_rows};
end

always @(posedge core_clk) begin
    if (rst) begin
        line_valid_out <= 1'b0;
        frame_valid_out <= 1'b0;
        pixel_data_out <= {DATA_W{1'b0}};
        pixel_clock_out <= 1'b0;
        shutter_row_out <= 16'h0000;
    end else begin
        pixel_clock_out <= pclk_raw;
        if (tick) begin
            frame_valid_out <= show && state_ff[0];
            line_valid_out <= show && state_ff[0]
                              && (col < {1'b0, WIN_COLS});
            pixel_data_out <= col[DATA_W-1:0] ^ row[DATA_W-1:0];
            if (!state_ff[2]) begin
                shutter_row_out <= shutter_sum[15:0];
            end
        end
    end
end

endmodule
`default_nettype wire

//--- tb/frame_timing_ctrl_props.sv
// checker for the apb slave and pixel link outputs
// sees only the ports of frame_timing_ctrl; bound at the foot
`timescale 1ns/1ps
`default_nettype none
module frame_timing_props (
    input wire logic core_clk, // clock
    input wire logic rst, // synchronous reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic line_valid_out, // line valid
    input wire logic frame_valid_out, // frame valid
    input wire logic pixel_clock_out // pixel clock
);
default clocking cb @(posedge core_clk);
endclocking
default disable iff (rst);
// words 8..13 are the only decoded ones
wire logic mapped = paddr[11:2] >= 10'h008 && paddr[11:2] <= 10'h00d;
setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
err_unmapped_a: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
err_mapped_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
rdata_idle_a: assert property (!pready |-> !prdata && !pslverr)
    else $error("read data outside access");
reset_quiet_a: assert property (disable iff (1'b0)
    rst |=> !pready && !line_valid_out && !frame_valid_out
    && !pixel_clock_out) else $error("outputs active in reset");
lv_in_fv_a: assert property (line_valid_out |-> frame_valid_out)
    else $error("line valid outside frame");
sync_hold_a: assert property ($changed(line_valid_out)
    |=> $stable(line_valid_out)) else $error("sync shorter than pixel");
endmodule
bind frame_timing_ctrl frame_timing_props frame_timing_props_i (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_valid_out(line_valid_out), .frame_valid_out(frame_valid_out),
    .pixel_clock_out(pixel_clock_out)
);
`default_nettype wire

//--- tb/pixel_capture_model.sv
// receiver model: counts pixels, lines and gap clocks of each frame
// samples on the edge away from the data change, like a real receiver
`timescale 1ns/1ps
`default_nettype none
module pixel_capture_model (
    input wire logic core_clk, // sampling clock
    input wire logic pck, // pixel clock from the block
    input wire logic inv, // capture on the rising edge when set
    input wire logic lv, // line valid
    input wire logic fv, // frame valid
    input wire logic [7:0] pd, // pixel data
    output var int last_pix, // last pixel taken in a line
    output var int line_len, // pixels in the last line
    output var int rows, // lines in the last frame
    output var int gap // pixel clocks between frames
);
logic pck_q = 1'b0;
logic lv_q = 1'b0;
logic fv_q = 1'b0;
int pix = 0;
int ln = 0;
int gp = 0;
always @(posedge core_clk) begin
    pck_q <= pck;
    if (pck !== pck_q && pck === inv) begin
        if (lv) begin
            pix = pix + 1;
            last_pix = pd;
        end else if (lv_q) begin
            line_len = pix;
            pix = 0;
            ln = ln + 1;
        end
        if (fv && !fv_q) begin
            gap = gp;
        end
        if (!fv && fv_q) begin
            rows = ln;
            ln = 0;
        end
        gp = fv ? 0 : gp + 1;
        lv_q = lv;
        fv_q = fv;
    end
end
endmodule
`default_nettype wire

//--- tb/frame_timing_ctrl_tb.sv
// self-checking bench for the frame timing and pixel clock block
// assumes a small window so that whole frames run in a few thousand cycles
`timescale 1ns/1ps
`default_nettype none
module frame_timing_ctrl_tb;
localparam int COLS = 8;
localparam int HB = 2;
logic core_clk = 1'b0;
logic rst = 1'b1;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0;
logic inv = 1'b0;
wire [31:0] prdata;
wire pready, pslverr, lv, fv, pck;
wire [7:0] pdat;
wire [15:0] srow;
int line_len, rows, gap, miscompares = 0, check_count = 0, cycles = 0;
int last_pix;
logic [31:0] seed = 32'h91f4e506;
logic [31:0] rd;
logic err;
logic [31:0] mdl [0:4];
// bits beyond each field read back as zero
logic [31:0] msk [0:4] = '{32'h7fff, 32'hffff, 32'h1ff, 32'h3fff, 32'h7};
// speed, low power, invert, delay; delay kept below the period
int tbl [0:4][0:3] = '{'{1,0,0,0}, '{3,0,1,2}, '{0,0,0,1},
    '{2,1,1,3}, '{4,1,0,5}};
frame_timing_ctrl #(.DATA_W(8), .WIN_ROWS(11'h004), .WIN_COLS(11'h008),
    .HBLANK(11'h002)) frame_timing_ctrl_i (.core_clk(core_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_valid_out(lv), .frame_valid_out(fv),
    .pixel_data_out(pdat), .pixel_clock_out(pck), .shutter_row_out(srow));
pixel_capture_model pixel_capture_model_i (.core_clk(core_clk),
    .pck(pck), .inv(inv), .lv(lv), .fv(fv), .pd(pdat),
    .last_pix(last_pix), .line_len(line_len),
    .rows(rows), .gap(gap));
initial begin
    forever #20 core_clk = ~core_clk;
end
always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
        miscompares++;
        end_of_test;
    end
end
function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
        miscompares++;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic end_of_test;
    if (miscompares == 0 && check_count > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask
task automatic apb(input logic w, input int idx, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= 12'(idx * 4);
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
        @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
endtask
task automatic wr(input int idx, input logic [31:0] d);
    apb(1'b1, idx, d);
    mdl[idx - 8] = d & msk[idx - 8];
    check(32'(err), 32'h0);
endtask
task automatic rdchk(input int idx);
    apb(1'b0, idx, 32'h0);
    check(rd, mdl[idx - 8]);
endtask
task automatic defaults;
    mdl = '{32'h11, 32'h219, 32'h11, 32'h0, 32'h0};
    for (int i = 8; i < 13; i++) begin
        rdchk(i);
    end
endtask
task automatic wait_frames(input int n);
    repeat (n) @(posedge fv);
endtask
// offset of the data-change clock edge after a sync change, then the period
task automatic measure(input int per, input int d);
    int k;
    logic lv0, p0;
    k = -1;
    @(posedge core_clk);
    lv0 = lv;
    while (k < 0 || !(pck !== p0 && pck === ~inv)) begin
        p0 = pck;
        @(posedge core_clk);
        if (lv !== lv0) k = 0;
        else if (k >= 0) k++;
        lv0 = lv;
    end
    check(k, d);
    k = 0;
    do begin
        p0 = pck;
        @(posedge core_clk);
        k++;
    end while (!(pck !== p0 && pck === ~inv));
    check(k, per);
endtask
initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    defaults;
    apb(1'b0, 15, 32'h0);
    check({rd[30:0], err}, 32'h1);
    // hold keeps random blanking, integration and speed values out of the running frame; delay and invert apply at once
    wr(12, 32'h1);
    for (int i = 8; i < 12; i++) begin
        wr(i, xs());
        rdchk(i);
    end
    wr(8, 32'h2);
    wr(11, 32'h5);
    for (int i = 0; i < 5; i++) begin
        inv = (tbl[i][2] != 0);
        wr(10, tbl[i][0] | tbl[i][3] << 4 | tbl[i][2] << 8);
        wr(12, 2 | tbl[i][1] << 2);
        // one frame more at first, so both sides of the gap use new blanking
        wait_frames(i == 0 ? 3 : 2);
        measure(2 * (tbl[i][0] == 0 ? 1 : tbl[i][0]) * (tbl[i][1] + 1),
            tbl[i][3]);
        if (i == 0) begin
            check(line_len, COLS);
            check(rows, 4);
            check(gap, 2 * (COLS + HB) + 5);
            check(last_pix, COLS - 1);
            check(srow, mdl[1] % (4 + 2));
        end
    end
    wr(12, 32'h3);
    wr(10, 32'h2);
    wait_frames(2);
    measure(16, 0);
    wr(12, 32'h2);
    wait_frames(2);
    measure(4, 0);
    // all frames off: the frame after a blanking change stays hidden
    wr(12, 32'h0);
    wr(11, 32'h3);
    do begin
        apb(1'b0, 13, 32'h0);
    end while (rd[2] !== 1'b1);
    check({29'h0, rd[2:0]}, 32'h6);
    wait_frames(1);
    apb(1'b0, 13, 32'h0);
    check({29'h0, rd[2:0]}, 32'h3);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    defaults;
    end_of_test;
end
endmodule
`default_nettype wire
